// *** rtl/i2cs_defines.svh ***
// Offsets, field positions, reset values and timing counts of the I2C slave.
// Assumes APB with 32-bit data, one aligned word per register.
`ifndef I2CS_DEFINES_SVH
`define I2CS_DEFINES_SVH

// =====================================================================
// Register byte offsets
`define I2CS_OFF_CTRL_A   12'h000
`define I2CS_OFF_CTRL_B   12'h004
`define I2CS_OFF_OWN_ADDR 12'h008
`define I2CS_OFF_DATA     12'h00C

// =====================================================================
// Control A fields
`define I2CS_A_ENABLE     0
`define I2CS_A_IRQ_EN     1
`define I2CS_A_MODE_LSB   5
`define I2CS_MODE_I2C     3'h6

// =====================================================================
// Control B fields
`define I2CS_B_ACK_RX     0
`define I2CS_B_DIR        2
`define I2CS_B_ACK_TX     3
`define I2CS_B_TX_MODE    4
`define I2CS_B_BUSY       5
`define I2CS_B_MATCH      6
`define I2CS_B_DONE       7

// =====================================================================
// Reset values
`define I2CS_RST_CTRL_A   8'h00
`define I2CS_RST_OWN_ADDR 8'h00
`define I2CS_RST_DATA     8'h00

// =====================================================================
// Timing: bits per byte frame and bit of the acknowledge
`define I2CS_BITS_BYTE    4'h8
`define I2CS_ACK_BIT      4'h8

`endif

// *** rtl/i2cs_pkg.sv ***
// Types shared by the I2C slave files.
// Assumes the defines header supplies the register and timing numbers; the state codes are set here.
package i2cs_pkg;
   // ==================================================================
   // Synchronised bus line levels and events
   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } i2cs_line_t;

   // ==================================================================
   // Serial engine states
   typedef enum logic [4:0] {
      I2CS_IDLE = 5'b00001,
      I2CS_ADDR = 5'b00010,
      I2CS_ACKA = 5'b00100,
      I2CS_DATA = 5'b01000,
      I2CS_ACKD = 5'b10000
   } i2cs_state_t;
endpackage

// *** rtl/i2cs_line_sync.sv ***
// Three-stage synchroniser and condition detector for SCL and SDA.
// Assumes the pins are asynchronous to pclk.
module i2cs_line_sync
   import i2cs_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Raw pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   // Filtered levels and events
   output i2cs_line_t      line
);
   // =================================================================
   // Sync stages; a level counts once stages two and three agree
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   logic       scl_f_q;
   logic       sda_f_q;
   wire        scl_ok = (scl_q[1] == scl_q[2]);
   wire        sda_ok = (sda_q[1] == sda_q[2]);
   wire        scl_d  = scl_ok ? scl_q[2] : scl_f_q;
   wire        sda_d  = sda_ok ? sda_q[2] : sda_f_q;

   // Shift registers, idle bus is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q   <= 3'h7;
         sda_q   <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
      end else begin
         scl_q   <= {scl_q[1:0], scl_in};
         sda_q   <= {sda_q[1:0], sda_in};
         scl_f_q <= scl_d;
         sda_f_q <= sda_d;
      end
   end

   // Events from filtered levels
   assign line.scl      = scl_f_q;
   assign line.sda      = sda_f_q;
   assign line.scl_rise = scl_d & ~scl_f_q;
   assign line.scl_fall = ~scl_d & scl_f_q;
   assign line.start    = scl_f_q & scl_d & sda_f_q & ~sda_d; // [RULE_01]
   assign line.stop     = scl_f_q & scl_d & ~sda_f_q & sda_d; // [RULE_23]
endmodule

// *** rtl/i2cs_slave.sv ***
// APB-reached I2C slave interface: address match, byte shift, ACK, stretch.
// Assumes an external master drives SCL; SDA and SCL are open drain.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`include "i2cs_defines.svh"

//
// Contract
// (RULE_01) START is SDA falling while SCL is high.
// (RULE_02) START sets the bus busy flag.
// (RULE_03) Slave only; never drives a START.
// (RULE_04) Receive 7-bit calling address after START, compare with own address.
// (RULE_05) Address match raises the interrupt request.
// (RULE_06) Address match sets the address match flag.
// (RULE_07) Eighth bit after address goes to the direction flag.
// (RULE_08) Matched address is acknowledged low on the ninth bit.
// (RULE_09) Interrupt from address match or byte done; match flag tells.
// (RULE_10) SCL held low after match until data written or read.
// (RULE_11) Software sets tx mode for master read, clears for master write.
// (RULE_12) Master sends STOP when its address is not acknowledged.
// (RULE_13) Bytes are 8 bits MSB first, only after address ACK.
// (RULE_14) Receiver drives ack_to_send onto SDA on ninth clock.
// (RULE_15) Transmitter records master ACK; on NACK releases SDA until STOP.
// (RULE_16) Master sends STOP after NACK once SDA released.
// (RULE_17) Bytes pass through the shared data register both ways.
// (RULE_18) Software writes address, then enable, then interrupt enable.
// (RULE_19) STOP clears the bus busy flag.
// (RULE_20) Byte done flag low during a byte, high with interrupt after.
// (RULE_21) Mode field must be 110 for the I2C function.
// (RULE_22) Own address register holds address in bits 7..1, bit 0 unused.
// (RULE_23) STOP is SDA rising while SCL is high, ends transaction.
module i2cs_slave
   import i2cs_pkg::*;
(
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // I2C pins, open drain
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // Request to the interrupt controller
   output logic             serial_irq
);
   // =================================================================
   // Line conditioning
   i2cs_line_t line;

   i2cs_line_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .line    (line)
   );

   // =================================================================
   // Registers
   logic [7:0]  serial_ctrl_a_q;
   logic [7:0]  own_address_reg_q;
   logic [7:0]  shift_data_reg_q;
   logic        tx_mode_sel_q;
   logic        ack_to_send_q;
   logic        ack_received_flag_q;
   logic        dir_request_flag_q;
   logic        bus_busy_flag_q;
   logic        addr_match_flag_q;
   logic        byte_done_flag_q;
   logic        hold_q;
   logic        nack_wait_q;
   i2cs_state_t state_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  sh_q;
   logic        sda_drv_q;
   logic        irq_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic [1:0]  rel_q;

   // =================================================================
   // APB decode; always ready, one access cycle
   wire acc       = psel & penable;
   wire wr        = acc & pwrite;
   wire rd        = acc & ~pwrite;
   wire hit_a     = (paddr == `I2CS_OFF_CTRL_A);
   wire hit_b     = (paddr == `I2CS_OFF_CTRL_B);
   wire hit_adr   = (paddr == `I2CS_OFF_OWN_ADDR);
   wire hit_dat   = (paddr == `I2CS_OFF_DATA);
   wire mapped    = hit_a | hit_b | hit_adr | hit_dat;
   wire wr_a      = wr & hit_a;
   wire wr_b      = wr & hit_b;
   wire wr_adr    = wr & hit_adr;
   wire wr_dat    = wr & hit_dat;
   wire rd_dat    = rd & hit_dat;
   wire rd_b      = rd & hit_b;

   // Control decode; mode 110 is required for the I2C function
   wire iface_enable      = serial_ctrl_a_q[`I2CS_A_ENABLE];
   wire serial_irq_enable = serial_ctrl_a_q[`I2CS_A_IRQ_EN];
   wire [2:0] serial_mode_field =
      serial_ctrl_a_q[`I2CS_A_MODE_LSB +: 3];
   wire active = iface_enable &
                 (serial_mode_field == `I2CS_MODE_I2C); // [RULE_21]

   wire [7:0] serial_ctrl_b = {byte_done_flag_q, addr_match_flag_q,
                               bus_busy_flag_q, tx_mode_sel_q,
                               ack_to_send_q, dir_request_flag_q,
                               1'b0, ack_received_flag_q};

   // Read mux
   wire [7:0] rd_byte = hit_a   ? serial_ctrl_a_q :
                        hit_b   ? serial_ctrl_b :
                        hit_adr ? {own_address_reg_q[7:1], 1'b0} :
                        hit_dat ? shift_data_reg_q : 8'h00;

   // =================================================================
   // Serial engine decode
   wire in_addr   = (state_q == I2CS_ADDR);
   wire in_data   = (state_q == I2CS_DATA);
   wire in_acka   = (state_q == I2CS_ACKA);
   wire in_ackd   = (state_q == I2CS_ACKD);
   wire frame_end = (bit_cnt_q == `I2CS_BITS_BYTE - 4'h1);
   // Ninth bit period: from the eighth SCL fall to the ninth
   wire ack_slot  = (bit_cnt_q == `I2CS_ACK_BIT + 4'h1);
   // First bit comes straight from the register, so a late write counts
   wire tx_bit    = (bit_cnt_q == 4'h0) ? shift_data_reg_q[7] : sh_q[7];
   wire [7:0] sh_next = {sh_q[6:0], line.sda};  // MSB first [RULE_13]
   // Calling address compare on the eighth sampled bit [RULE_04]
   wire addr_hit  = in_addr & line.scl_rise & frame_end &
                    (sh_q[6:0] == own_address_reg_q[7:1]); // [RULE_22]
   wire byte_in   = in_data & line.scl_rise & frame_end;
   wire abort     = line.stop | line.start | ~active;
   // Release of stretching by software access [RULE_10]
   wire release_h = hold_q & (tx_mode_sel_q ? wr_dat : rd_dat);

   // Control A, own address, tx mode and ack bits written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_ctrl_a_q   <= `I2CS_RST_CTRL_A;
         own_address_reg_q <= `I2CS_RST_OWN_ADDR;
         tx_mode_sel_q     <= 1'b0;
         ack_to_send_q     <= 1'b0;
      end else begin
         if (wr_a)   serial_ctrl_a_q   <= pwdata[7:0];
         if (wr_adr) own_address_reg_q <= pwdata[7:0];
         if (wr_b) begin
            tx_mode_sel_q <= pwdata[`I2CS_B_TX_MODE]; // [RULE_11]
            ack_to_send_q <= pwdata[`I2CS_B_ACK_TX];
         end
      end
   end

   // Shared data register: software writes, received bytes land [RULE_17]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         shift_data_reg_q <= `I2CS_RST_DATA;
      else if (byte_in & ~tx_mode_sel_q)
         shift_data_reg_q <= sh_next;
      else if (wr_dat)
         shift_data_reg_q <= pwdata[7:0];
   end

   // Bus busy: START sets, STOP clears [RULE_02] [RULE_19]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         bus_busy_flag_q <= 1'b0;
      else if (!active)
         bus_busy_flag_q <= 1'b0;
      else if (line.start)
         bus_busy_flag_q <= 1'b1; // [RULE_02]
      else if (line.stop)
         bus_busy_flag_q <= 1'b0; // [RULE_19]
   end

   // Status flags; hardware sets win over clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_match_flag_q   <= 1'b0;
         dir_request_flag_q  <= 1'b0;
         byte_done_flag_q    <= 1'b1;
         ack_received_flag_q <= 1'b0;
      end else begin
         if (addr_hit) begin
            addr_match_flag_q  <= 1'b1;         // [RULE_06]
            dir_request_flag_q <= line.sda;     // [RULE_07]
         end else if (line.start | (in_data & line.scl_fall))
            addr_match_flag_q  <= 1'b0;
         // Low while a byte moves, high when eight bits done [RULE_20]
         if (addr_hit | (in_data & frame_end & line.scl_rise))
            byte_done_flag_q <= 1'b1;
         else if (in_data & line.scl_rise)
            byte_done_flag_q <= 1'b0;
         // Master acknowledge captured as transmitter [RULE_15]
         if (in_ackd & tx_mode_sel_q & line.scl_rise)
            ack_received_flag_q <= line.sda;
      end
   end

   // Serial state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= I2CS_IDLE;
         bit_cnt_q <= 4'h0;
         sh_q      <= 8'h00;
         nack_wait_q <= 1'b0;
      end else if (abort) begin
         // STOP ends all; START restarts address phase [RULE_23]
         state_q     <= (line.start & active) ? I2CS_ADDR : I2CS_IDLE;
         bit_cnt_q   <= 4'h0;
         nack_wait_q <= 1'b0;
      end else begin
         unique case (state_q)
            I2CS_IDLE: ;
            I2CS_ADDR: if (line.scl_rise) begin
               sh_q      <= sh_next;
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (frame_end)
                  state_q <= addr_hit ? I2CS_ACKA : I2CS_IDLE;
            end
            I2CS_ACKA: if (line.scl_fall) begin
               // First fall opens the ACK slot, the second ends it
               if (!ack_slot)
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               else begin
                  state_q   <= I2CS_DATA; // data only after ACK [RULE_13]
                  bit_cnt_q <= 4'h0;
               end
            end
            I2CS_DATA: begin
               // Until the first rise the byte follows the data register
               if (tx_mode_sel_q & bit_cnt_q == 4'h0)
                  sh_q <= shift_data_reg_q;
               else if (line.scl_fall & tx_mode_sel_q)
                  sh_q <= {sh_q[6:0], 1'b0};
               if (line.scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (!tx_mode_sel_q)
                     sh_q <= sh_next;
                  if (frame_end)
                     state_q <= I2CS_ACKD;
               end
            end
            I2CS_ACKD: begin
               if (line.scl_rise & tx_mode_sel_q & line.sda)
                  nack_wait_q <= 1'b1;   // wait for STOP [RULE_15]
               if (line.scl_fall & ~ack_slot)
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               else if (line.scl_fall & ~nack_wait_q) begin
                  state_q   <= I2CS_DATA;
                  bit_cnt_q <= 4'h0;
               end
            end
         endcase
      end
   end

   // Clock stretch after match or byte, until software access [RULE_10]
   // Release lags two cycles so the first data bit is out before SCL rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 1'b0;
         rel_q  <= 2'b00;
      end else begin
         rel_q <= {rel_q[0], release_h};
         if (abort | rel_q[1])
            hold_q <= 1'b0;
         else if ((in_acka | in_ackd) & line.scl_fall & ack_slot &
                  ~nack_wait_q)
            hold_q <= 1'b1;
      end
   end

   // SDA drive; slave never makes START or STOP [RULE_03]
   wire drv_ack_a = in_acka & ack_slot;               // [RULE_08]
   wire drv_ack_d = in_ackd & ack_slot & ~tx_mode_sel_q &
                    ~ack_to_send_q;                   // [RULE_14]
   wire drv_data  = in_data & tx_mode_sel_q & ~tx_bit & ~nack_wait_q;
   wire sda_low   = active & (drv_ack_a | drv_ack_d | drv_data);
   // Changes only while SCL is seen low, except that an abort releases it at any time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sda_drv_q <= 1'b0;
      else if (~line.scl | abort)
         sda_drv_q <= sda_low & ~abort;
   end

   // Interrupt request: match or byte done [RULE_05] [RULE_09]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_q <= 1'b0;
      else if (addr_hit | byte_in)
         irq_q <= serial_irq_enable;
      else if (rd_b | ~serial_irq_enable)
         irq_q <= 1'b0;
   end

   // APB read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         // Error latched in setup, stands for the access phase
         pslverr_q <= psel & ~penable & ~mapped;
         if (psel & ~penable & ~pwrite)
            prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   // =================================================================
   // Outputs
   assign prdata     = prdata_q;
   assign pready     = 1'b1;
   assign pslverr    = pslverr_q;
   assign scl_out    = 1'b0;
   assign scl_oe     = hold_q;
   assign sda_out    = 1'b0;
   assign sda_oe     = sda_drv_q;
   assign serial_irq = irq_q;
endmodule

// *** tb/i2cs_slave_properties.sv ***
// Concurrent checks on the ports of the I2C slave top.
// Assumes binding to i2cs_slave; sees only its ports.
`include "i2cs_defines.svh"
module i2cs_slave_props (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // I2C pins and request
   input wire logic        scl_in,
   input wire logic        scl_out,
   input wire logic        scl_oe,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        serial_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ================================================
   // Cycles since the last SCL pin edge, saturating
   logic       scl_q;
   logic [7:0] age_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         age_q <= 8'hFF;
      end else begin
         scl_q <= scl_in;
         age_q <= (scl_in != scl_q) ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
      end
   end
   // Accesses that may end a stretch or clear the request
   wire acc_w = psel && penable;
   wire rel_w = acc_w && (pwrite || paddr == `I2CS_OFF_DATA);

   chk_pins_low: assert property (!scl_out && !sda_out)
      else $error("open drain data driven high");
   chk_no_start: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda drive changed while scl high");
   chk_stretch_start: assert property ($rose(scl_oe) |-> !scl_in)
      else $error("stretch began while scl high");
   chk_stretch_hold: assert property (
      scl_oe && !rel_w && !$past(rel_w) && !$past(rel_w, 2) |=> scl_oe)
      else $error("stretch ended without data access");
   chk_irq_hold: assert property (
      serial_irq && !acc_w && !$past(acc_w) |=> serial_irq)
      else $error("request dropped without access");
   chk_irq_on_edge: assert property (
      $rose(serial_irq) |-> age_q < 8'h10)
      else $error("request not tied to an scl edge");
   chk_map_err: assert property (
      acc_w && paddr[1:0] == 2'b00 |-> pslverr == (paddr > `I2CS_OFF_DATA))
      else $error("slave error flag wrong for address");
   chk_ready_now: assert property (acc_w |-> pready)
      else $error("access phase without ready");
endmodule

// *** tb/i2cs_master_model.sv ***
// Behavioural I2C bus master for the slave bench.
// Assumes the bench forms open-drain lines with pull-ups from the pulls.
module i2cs_master_model (
   // Resolved line levels
   input  wire logic scl,
   input  wire logic sda,
   // Pulls, high drives the line low
   output logic      scl_pull,
   output logic      sda_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam real Q = 31.25; // Quarter of a 125 ns bit
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // Slave may hold SCL low; bounded so a stuck line cannot hang
   task automatic wait_scl();
      for (int i = 0; i < 4000 && scl !== 1'b1; i++) #5;
   endtask
   // SDA falls while SCL high; only this side starts
   task automatic start();
      sda_pull = 1'b1;
      #(2 * Q);
      scl_pull = 1'b1;
      #Q;
   endtask
   // SDA rises while SCL high, after a NACK too
   task automatic stop();
      sda_pull = 1'b1;
      #Q;
      scl_pull = 1'b0;
      wait_scl();
      #Q;
      sda_pull = 1'b0;
      #(2 * Q);
   endtask
   // Nine clocks, MSB first, ninth is the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ack,
                       output logic [7:0] q, output logic sack);
      logic [8:0] v;
      logic [8:0] r;
      v = {d, ack};
      for (int i = 8; i >= 0; i--) begin
         sda_pull = ~v[i];
         #Q;
         scl_pull = 1'b0;
         wait_scl();
         #Q;
         r[i] = sda;
         #Q;
         scl_pull = 1'b1;
         #Q;
      end
      q = r[8:1];
      sack = r[0];
   endtask
endmodule

// *** tb/i2c_slave_interface_tb.sv ***
// Self-checking bench for the APB-reached I2C slave.
// Assumes the master model and the bound property checker.
`include "i2cs_defines.svh"
module i2c_slave_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, er, sack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe;
   logic        serial_irq, m_scl, m_sda;
   logic [6:0]  own;
   logic [7:0]  d, q;
   int          n_fail, tests_run, cyc;
   // Open-drain lines with pull-ups
   wire scl_w = ~(m_scl | scl_oe);
   wire sda_w = ~(m_sda | sda_oe);
   i2cs_slave u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .serial_irq(serial_irq));
   i2cs_master_model u_mst (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl),
      .sda_pull(m_sda));
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;
   // ================================================
   // Bus cycles, comparisons, expectations
   function automatic logic [31:0] fb(input int p, input bit v);
      return v ? (32'h1 << p) : 32'h0;
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, r & m);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         summarize();
      end
   end
   // ================================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      n_fail = 0;
      tests_run = 0;
      cyc = 0;
      void'($urandom(32'hF7E0));
      own = 7'($urandom);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rdc(`I2CS_OFF_CTRL_A, 32'hFFFFFFFF, 32'h0, "ctrl_a_rst");
      rdc(`I2CS_OFF_CTRL_B, 32'hFFFFFFFF, fb(`I2CS_B_DONE, 1), "ctrl_b_rst");
      rdc(`I2CS_OFF_OWN_ADDR, 32'hFFFFFFFF, 32'h0, "own_rst");
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      chk("unmapped_err", 1, er);
      rdc(12'h010, 32'hFFFFFFFF, 32'h0, "unmapped_rd");
      $display("test reset done");
      apb(1'b1, `I2CS_OFF_OWN_ADDR, {24'h0, own, 1'b1});
      rdc(`I2CS_OFF_OWN_ADDR, 32'hFF, {24'h0, own, 1'b0}, "own");
      apb(1'b1, `I2CS_OFF_CTRL_A, 32'hC1);
      apb(1'b1, `I2CS_OFF_CTRL_A, 32'hC3);
      $display("test init done");
      u_mst.start();
      u_mst.xfer({own ^ 7'h01, 1'b0}, 1'b1, q, sack);
      chk("nack_other", 1, sack);
      chk("irq_other", 0, serial_irq);
      rdc(`I2CS_OFF_CTRL_B, 32'h60, fb(`I2CS_B_BUSY, 1), "busy");
      u_mst.stop();
      rdc(`I2CS_OFF_CTRL_B, 32'h20, 32'h0, "idle");
      $display("test other address done");
      u_mst.start();
      u_mst.xfer({own, 1'b0}, 1'b1, q, sack);
      chk("ack_addr_w", 0, sack);
      chk("irq_match", 1, serial_irq);
      chk("stretch", 1, scl_oe);
      rdc(`I2CS_OFF_CTRL_B, 32'h64, 32'h60, "match_w");
      @(posedge pclk);
      chk("irq_clr", 0, serial_irq);
      apb(1'b1, `I2CS_OFF_CTRL_B, 32'h0);
      apb(1'b0, `I2CS_OFF_DATA, 32'h0);
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 8'h80 : 8'($urandom);
         if (k == 3) apb(1'b1, `I2CS_OFF_CTRL_B, fb(`I2CS_B_ACK_TX, 1));
         u_mst.xfer(d, 1'b1, q, sack);
         chk("ack_rx", 32'(k == 3), sack);
         chk("irq_byte", 1, serial_irq);
         rdc(`I2CS_OFF_CTRL_B, 32'hC0, 32'h80, "done_rx");
         rdc(`I2CS_OFF_DATA, 32'hFF, {24'h0, d}, "rx_byte");
      end
      u_mst.stop();
      rdc(`I2CS_OFF_CTRL_B, 32'h20, 32'h0, "idle_w");
      $display("test master write done");
      u_mst.start();
      u_mst.xfer({own, 1'b1}, 1'b1, q, sack);
      chk("ack_addr_r", 0, sack);
      rdc(`I2CS_OFF_CTRL_B, 32'h44, 32'h44, "match_r");
      apb(1'b1, `I2CS_OFF_CTRL_B, fb(`I2CS_B_TX_MODE, 1));
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 8'h01 : 8'($urandom);
         apb(1'b1, `I2CS_OFF_DATA, {24'h0, d});
         u_mst.xfer(8'hFF, k == 2, q, sack);
         chk("tx_byte", d, q);
         rdc(`I2CS_OFF_CTRL_B, 32'h11, fb(`I2CS_B_ACK_RX, k == 2) | 32'h10, "ack_seen");
      end
      u_mst.stop();
      chk("sda_free", 0, sda_oe);
      rdc(`I2CS_OFF_CTRL_B, 32'h20, 32'h0, "idle_r");
      $display("test master read done");
      summarize();
   end
endmodule
bind i2cs_slave i2cs_slave_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .serial_irq(serial_irq));
